// File: hdl/turn_pkg.sv
// Shared constants and types for the query/response turnaround ends
package turn_pkg;

    // Clock and tick timing
    localparam int CLK_HZ    = 10_000_000;
    localparam int MS_PER_S  = 1000;
    localparam int TICK_MS   = 1;
    localparam int TICK_CYC  = CLK_HZ / MS_PER_S * TICK_MS;

    // Slave turnaround timing
    localparam logic [7:0] DELAY_DEF_MS  = 8'h05;
    localparam int         RECOV_MS      = 1;
    localparam int         RECOV_TICKS   = RECOV_MS / TICK_MS + 1;
    localparam int         LATE_MARGIN   = 1;

    // Master timeout formula terms and retry limit
    localparam int         SAFETY        = 3;
    localparam int         FRAME_BITS    = 10;
    localparam int         BYTE_PAD      = 8;
    localparam logic [1:0] NRT           = 2'h3;

    // Station numbers run 0 to 4'hf
    typedef logic [3:0] station_t;
    localparam station_t STATION_MAX = 4'hf;

    // Bit rate selection code
    typedef logic [3:0] baud_t;
    localparam baud_t BAUD_DEF = 4'h4;

    // Access kind of a query, one processing bound each
    typedef enum logic [2:0] {
        KIND_REG,
        KIND_P1_RD,
        KIND_P1_WR,
        KIND_P1_RW,
        KIND_P9_RD,
        KIND_P9_WR,
        KIND_P9_RW
    } kind_e;

    localparam logic [7:0] PROC_REG_MS   = 8'h01;
    localparam logic [7:0] PROC_P1_RD_MS = 8'h04;
    localparam logic [7:0] PROC_P1_WR_MS = 8'h0f;
    localparam logic [7:0] PROC_P1_RW_MS = 8'h12;
    localparam logic [7:0] PROC_P9_RD_MS = 8'h09;
    localparam logic [7:0] PROC_P9_WR_MS = 8'h5a;
    localparam logic [7:0] PROC_P9_RW_MS = 8'h62;

    function automatic logic [7:0] proc_limit_ms(kind_e k);
        case (k)
            KIND_REG:   return PROC_REG_MS;
            KIND_P1_RD: return PROC_P1_RD_MS;
            KIND_P1_WR: return PROC_P1_WR_MS;
            KIND_P1_RW: return PROC_P1_RW_MS;
            KIND_P9_RD: return PROC_P9_RD_MS;
            KIND_P9_WR: return PROC_P9_WR_MS;
            default:    return PROC_P9_RW_MS;
        endcase
    endfunction

    function automatic int baud_bps(baud_t b);
        case (b)
            4'h0:    return 9600;
            4'h1:    return 14400;
            4'h2:    return 19200;
            4'h3:    return 28800;
            4'h4:    return 38400;
            4'h5:    return 57600;
            4'h6:    return 76800;
            4'h7:    return 115200;
            4'h8:    return 230400;
            default: return 38400;
        endcase
    endfunction

endpackage

// File: hdl/turn_if.sv
// Frame-level link between the master end and one slave end
`timescale 1ns/1ps
interface turn_if;
    import turn_pkg::*;

    // Query, master to slave
    logic     q_valid;
    station_t q_station;
    logic     q_bcast;
    kind_e    q_kind;
    baud_t    q_baud;
    logic     rx_en;

    // Response, slave to master
    logic     tx_en;
    logic     r_valid;
    station_t r_station;
    logic     r_err;

    modport master (
        output q_valid, q_station, q_bcast, q_kind, q_baud, rx_en,
        input  tx_en, r_valid, r_station, r_err
    );

    modport slave (
        input  q_valid, q_station, q_bcast, q_kind, q_baud, rx_en,
        output tx_en, r_valid, r_station, r_err
    );
endinterface

// File: hdl/ms_tick.sv
// Free-running millisecond tick generator
`timescale 1ns/1ps
module ms_tick #(
    parameter int TICK_CYC = turn_pkg::TICK_CYC
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // One-cycle tick
    output logic      tick
);
    import turn_pkg::*;

    localparam int CW = $clog2(TICK_CYC);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYC - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } tick_s;

    tick_s q, d;

    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (q.cnt == LAST) begin
            d.cnt  = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;
endmodule

// File: hdl/turn_slave.sv
// Slave end: station match, processing bound, turnaround and recovery
// Contract
// RULE1 - One query, one response, one unit
// RULE2 - Both ends use same bit rate
// RULE3 - Bit rate changes only after transfer, restart
// RULE4 - Station number 0 to hex F
// RULE5 - Response delay is minimum plus processing
// RULE6 - Transmitter stays off until delay elapses
// RULE7 - Master receiver on before delay expires
// RULE8 - Ready again within 1 ms after response
// RULE9 - Register access processed within 1 ms
// RULE10 - One position: 4/15/18 ms bounds
// RULE11 - Nine positions: 9/90/98 ms bounds
// RULE12 - Master waits unless broadcast
// RULE13 - Timeout: 3*proc + delay + 10*bytes/kbps
// RULE14 - Byte term is response length plus 8
// RULE15 - Master may resend after timeout
// RULE16 - Three retries, then unrecoverable error
// RULE17 - Clear retries on response; respect recovery
`timescale 1ns/1ps
module turn_slave #(
    parameter int TICK_CYC = turn_pkg::TICK_CYC
) (
    // Clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              RST_B,
    // Link
    turn_if.slave                  lk,
    // Station switch pins, asynchronous
    input  wire turn_pkg::station_t STATION_PIN,
    // Configuration parameters
    input  wire turn_pkg::baud_t   CFG_BAUD,
    input  wire logic [7:0]        CFG_DELAY_MS,
    input  wire logic              CFG_XFER,
    input  wire logic              RESTART,
    // Processing handshake
    output logic                   PROC_REQ,
    output turn_pkg::kind_e        PROC_KIND,
    input  wire logic              PROC_DONE,
    // Serializer
    input  wire logic              TX_DONE,
    // Status
    output turn_pkg::baud_t        ACTIVE_BAUD,
    output logic [7:0]             ACTIVE_DELAY_MS,
    output turn_pkg::station_t     STATION,
    output logic                   READY,
    output logic                   PROC_LATE,
    output logic                   Q_DROP
);
    import turn_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE,
        S_PROC,
        S_DELAY,
        S_TX,
        S_RECOV
    } slave_state_e;

    typedef struct packed {
        slave_state_e st;
        station_t     sync1;
        station_t     sync2;
        baud_t        pend_baud;
        logic [7:0]   pend_delay;
        baud_t        act_baud;
        logic [7:0]   act_delay;
        kind_e        kind;
        logic         bcast;
        station_t     r_station;
        logic [8:0]   cnt;
        logic         err;
        logic         proc_req;
        logic         proc_late;
        logic         drop;
        logic         tx_en;
        logic         r_valid;
    } slave_s;

    slave_s q, d;
    logic   tick;

    ms_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .clk_sys (CLK_SYS),
        .rst_b   (RST_B),
        .tick    (tick)
    );

    // Processing is late once the bound has surely passed at tick grain
    function automatic logic proc_over(kind_e k, logic [8:0] c);
        return c > 9'(proc_limit_ms(k)) + 9'(LATE_MARGIN);
    endfunction

    always_comb begin
        d           = q;
        d.proc_req  = 1'b0;
        d.proc_late = 1'b0;
        d.drop      = 1'b0;
        d.r_valid   = 1'b0;
        d.sync1     = STATION_PIN;
        d.sync2     = q.sync1;
        if (tick) begin
            d.cnt = q.cnt + 9'h001;
        end

        // RULE3 staged bit rate
        if (CFG_XFER) begin
            d.pend_baud  = CFG_BAUD;
            d.pend_delay = CFG_DELAY_MS;
        end

        case (q.st)
            S_IDLE: begin
                if (lk.q_valid) begin
                    // RULE2 foreign bit rate
                    if (lk.q_baud != q.act_baud) begin
                        d.drop = 1'b1;
                    // RULE4 station match
                    end else if (lk.q_bcast ||
                                 lk.q_station == q.sync2) begin
                        d.kind      = lk.q_kind;
                        d.bcast     = lk.q_bcast;
                        d.r_station = q.sync2;
                        d.err       = 1'b0;
                        d.cnt       = '0;
                        d.proc_req  = 1'b1;
                        d.st        = S_PROC;
                    end
                end
            end
            S_PROC: begin
                // RULE9 RULE10 RULE11 processing bounds
                if (PROC_DONE) begin
                    d.cnt = '0;
                    d.st  = q.bcast ? S_RECOV : S_DELAY;
                end else if (proc_over(q.kind, q.cnt)) begin
                    d.proc_late = 1'b1;
                    d.err       = 1'b1;
                    d.cnt       = '0;
                    d.st        = q.bcast ? S_RECOV : S_DELAY;
                end
            end
            S_DELAY: begin
                // RULE5 RULE6 delay follows processing
                if (q.cnt > {1'b0, q.act_delay}) begin
                    d.tx_en = 1'b1;
                    d.st    = S_TX;
                end
            end
            S_TX: begin
                // RULE1 one response closes the unit
                if (TX_DONE) begin
                    d.tx_en   = 1'b0;
                    d.r_valid = 1'b1;
                    d.cnt     = '0;
                    d.st      = S_RECOV;
                end
            end
            S_RECOV: begin
                // RULE8 ready by next tick
                if (tick) begin
                    d.st = S_IDLE;
                end
            end
            default: begin
                d.st = S_IDLE;
            end
        endcase

        // Queries during a unit are refused, never queued
        if (lk.q_valid && q.st != S_IDLE) begin
            d.drop = 1'b1;
        end

        // RULE3 new rate only at restart
        if (RESTART) begin
            d.act_baud  = q.pend_baud;
            d.act_delay = q.pend_delay;
            d.tx_en     = 1'b0;
            d.st        = S_IDLE;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            q            <= '0;
            q.st         <= S_IDLE;
            q.pend_baud  <= BAUD_DEF;
            q.act_baud   <= BAUD_DEF;
            q.pend_delay <= DELAY_DEF_MS;
            q.act_delay  <= DELAY_DEF_MS;
            q.kind       <= KIND_REG;
        end else begin
            q <= d;
        end
    end

    // Link outputs
    assign lk.tx_en     = q.tx_en;
    assign lk.r_valid   = q.r_valid;
    assign lk.r_station = q.r_station;
    assign lk.r_err     = q.err;

    // User side
    assign PROC_REQ        = q.proc_req;
    assign PROC_KIND       = q.kind;
    assign ACTIVE_BAUD     = q.act_baud;
    assign ACTIVE_DELAY_MS = q.act_delay;
    assign STATION         = q.sync2;
    assign READY           = (q.st == S_IDLE);
    assign PROC_LATE       = q.proc_late;
    assign Q_DROP          = q.drop;
endmodule

// File: hdl/turn_master.sv
// Master end: query issue, response timeout, retry and recovery
`timescale 1ns/1ps
module turn_master #(
    parameter int TICK_CYC = turn_pkg::TICK_CYC
) (
    // Clock and reset
    input  wire logic               CLK_SYS,
    input  wire logic               RST_B,
    // Link
    turn_if.master                  lk,
    // Command
    input  wire logic               CMD_VALID,
    output logic                    CMD_READY,
    input  wire turn_pkg::station_t CMD_STATION,
    input  wire logic               CMD_BCAST,
    input  wire turn_pkg::kind_e    CMD_KIND,
    input  wire logic [7:0]         CMD_RESP_LEN,
    // Configuration
    input  wire turn_pkg::baud_t    CFG_BAUD,
    input  wire logic [7:0]         CFG_DELAY_MS,
    // Result
    output logic                    DONE_OK,
    output logic                    RESP_ERR,
    output logic                    RETRY,
    output logic                    COMM_FAIL,
    output logic [1:0]              RETRY_COUNT,
    output logic [15:0]             TIMEOUT_MS
);
    import turn_pkg::*;

    typedef enum logic [1:0] {
        M_IDLE,
        M_WAIT,
        M_RECOV
    } master_state_e;

    typedef struct packed {
        master_state_e st;
        logic          q_valid;
        station_t      station;
        logic          bcast;
        kind_e         kind;
        baud_t         baud;
        logic          rx_en;
        logic [15:0]   tout;
        logic [15:0]   cnt;
        logic [1:0]    retry;
        logic          resend;
        logic          done_ok;
        logic          resp_err;
        logic          retry_p;
        logic          fail;
    } master_s;

    master_s q, d;
    logic    tick;

    ms_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .clk_sys (CLK_SYS),
        .rst_b   (RST_B),
        .tick    (tick)
    );

    // RULE13 RULE14 timeout in whole ms, byte term rounded up
    function automatic logic [15:0] tout_ms(kind_e k, logic [7:0] dly,
                                            logic [7:0] len, baud_t b);
        logic [31:0] bits;
        logic [31:0] bps;
        logic [31:0] t;
        bits = 32'(FRAME_BITS) * (32'(len) + 32'(BYTE_PAD))
             * 32'(MS_PER_S);
        bps  = 32'(baud_bps(b));
        t    = 32'(SAFETY) * 32'(proc_limit_ms(k)) + 32'(dly)
             + (bits + bps - 32'h1) / bps;
        return t[15:0];
    endfunction

    always_comb begin
        d          = q;
        d.q_valid  = 1'b0;
        d.done_ok  = 1'b0;
        d.retry_p  = 1'b0;
        d.fail     = 1'b0;
        if (tick) begin
            d.cnt = q.cnt + 16'h0001;
        end
        case (q.st)
            M_IDLE: begin
                if (CMD_VALID) begin
                    d.station = CMD_STATION;
                    d.bcast   = CMD_BCAST;
                    d.kind    = CMD_KIND;
                    // RULE2 rate sent with each query
                    d.baud    = CFG_BAUD;
                    d.tout    = tout_ms(CMD_KIND, CFG_DELAY_MS,
                                        CMD_RESP_LEN, CFG_BAUD);
                    d.retry   = 2'h0;
                    d.q_valid = 1'b1;
                    d.cnt     = '0;
                    // RULE7 RULE12 receiver on, except broadcast
                    d.rx_en   = !CMD_BCAST;
                    d.st      = CMD_BCAST ? M_RECOV : M_WAIT;
                end
            end
            M_WAIT: begin
                if (lk.r_valid && lk.r_station == q.station) begin
                    // RULE17 response clears retries
                    d.rx_en    = 1'b0;
                    d.done_ok  = 1'b1;
                    d.resp_err = lk.r_err;
                    d.retry    = 2'h0;
                    d.resend   = 1'b0;
                    d.cnt      = '0;
                    d.st       = M_RECOV;
                end else if (q.cnt > q.tout) begin
                    d.rx_en = 1'b0;
                    d.cnt   = '0;
                    d.st    = M_RECOV;
                    // RULE16 fail once retries exhausted
                    if (q.retry == NRT) begin
                        d.fail   = 1'b1;
                        d.retry  = 2'h0;
                        d.resend = 1'b0;
                    // RULE15 resend same query
                    end else begin
                        d.retry   = q.retry + 2'h1;
                        d.retry_p = 1'b1;
                        d.resend  = 1'b1;
                    end
                end
            end
            M_RECOV: begin
                // RULE17 hold off for slave recovery
                if (q.cnt >= 16'(RECOV_TICKS)) begin
                    d.cnt = '0;
                    if (q.resend) begin
                        d.resend  = 1'b0;
                        d.q_valid = 1'b1;
                        d.rx_en   = 1'b1;
                        d.st      = M_WAIT;
                    end else begin
                        d.st = M_IDLE;
                    end
                end
            end
            default: begin
                d.st = M_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            q      <= '0;
            q.st   <= M_IDLE;
            q.kind <= KIND_REG;
            q.baud <= BAUD_DEF;
        end else begin
            q <= d;
        end
    end

    // Link outputs
    assign lk.q_valid   = q.q_valid;
    assign lk.q_station = q.station;
    assign lk.q_bcast   = q.bcast;
    assign lk.q_kind    = q.kind;
    assign lk.q_baud    = q.baud;
    assign lk.rx_en     = q.rx_en;

    // User side
    assign CMD_READY   = (q.st == M_IDLE);
    assign DONE_OK     = q.done_ok;
    assign RESP_ERR    = q.resp_err;
    assign RETRY       = q.retry_p;
    assign COMM_FAIL   = q.fail;
    assign RETRY_COUNT = q.retry;
    assign TIMEOUT_MS  = q.tout;
endmodule

// File: verif/turn_sva.sv
// Concurrent checks on the link joining the master and slave ends
`timescale 1ns/1ps
module turn_sva #(
    parameter int TICK_CYC = turn_pkg::TICK_CYC,
    parameter int DLY_MS   = 5
) (
    // Clock and reset
    input wire logic               CLK_SYS,
    input wire logic               RST_B,
    // Query
    input wire logic               q_valid,
    input wire turn_pkg::station_t q_station,
    input wire logic               q_bcast,
    input wire turn_pkg::kind_e    q_kind,
    input wire turn_pkg::baud_t    q_baud,
    input wire logic               rx_en,
    // Response
    input wire logic               tx_en,
    input wire logic               r_valid,
    input wire turn_pkg::station_t r_station,
    input wire logic               r_err
);
    import turn_pkg::*;

    localparam int MIN_TX = DLY_MS * TICK_CYC;
    localparam int GAP_MIN = TICK_CYC - 1;

    logic [15:0] q_cnt_q;
    logic [15:0] gap_q;
    logic        rx_q;

    // Saturating counts: cycles since a query and since the receiver closed
    always_ff @(posedge CLK_SYS) begin
        rx_q <= rx_en;
        if (!RST_B || q_valid) begin
            q_cnt_q <= 16'h0000;
        end else if (q_cnt_q != 16'hffff) begin
            q_cnt_q <= q_cnt_q + 16'h0001;
        end
        if (!RST_B) begin
            gap_q <= 16'hffff;
        end else if (rx_q && !rx_en) begin
            gap_q <= 16'h0000;
        end else if (gap_q != 16'hffff) begin
            gap_q <= gap_q + 16'h0001;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);

    sequence s_tx_on;
        !tx_en ##1 tx_en;
    endsequence

    sequence s_tx_off;
        tx_en ##1 !tx_en;
    endsequence

    a_query_pulse: assert property (q_valid |=> !q_valid)
        else $error("query valid longer than one cycle");
    a_rx_with_query: assert property (q_valid |-> rx_en == !q_bcast)
        else $error("receiver state wrong at query");
    a_rx_before_tx: assert property (s_tx_on |-> rx_en)
        else $error("slave transmits while master receiver off");
    a_no_bcast_reply: assert property (tx_en |-> !q_bcast)
        else $error("transmitter on after broadcast");
    a_tx_min_delay: assert property (s_tx_on |-> q_cnt_q >= MIN_TX)
        else $error("transmitter on before minimum delay");
    a_tx_ends_resp: assert property (s_tx_off |-> r_valid)
        else $error("transmitter dropped without response end");
    a_resp_closes_tx: assert property (r_valid |-> $past(tx_en) && !tx_en)
        else $error("response end without transmitter");
    a_resp_station: assert property (r_valid |-> r_station == q_station)
        else $error("response from wrong station");
    a_rx_drops: assert property (r_valid |=> !rx_en)
        else $error("receiver still on after response");
    a_recovery_gap: assert property (q_valid |-> gap_q >= GAP_MIN)
        else $error("query inside recovery interval");
endmodule

// File: verif/tb.sv
// Self-checking bench: master and slave ends joined over the link
`timescale 1ns/1ps
module tb;
    import turn_pkg::*;

    localparam int TK  = 20;
    localparam int BPS = 38400;

    logic        CLK_SYS, RST_B;
    logic        cmd_valid, cmd_bcast, cmd_ready, cfg_xfer, restart;
    station_t    cmd_station, station_pin, station;
    kind_e       cmd_kind, proc_kind;
    logic [7:0]  cmd_len, act_delay, cfg_delay;
    baud_t       m_baud, s_baud, act_baud;
    logic        proc_req, proc_done, tx_done, ready, proc_late, q_drop;
    logic        done_ok, resp_err, retry, comm_fail, got_ok, got_fail;
    logic [1:0]  retry_count;
    logic [15:0] timeout_ms;
    int bad_count, n_tests, cyc, done_cyc, n_retry, n_late, n_drop, n_resp;
    int proc_wait, skip_done, n;
    int lim [7] = '{1, 4, 15, 18, 9, 90, 98};

    turn_if lk ();
    turn_master #(.TICK_CYC(TK)) turn_master_i (
        .CLK_SYS(CLK_SYS), .RST_B(RST_B), .lk(lk), .CMD_VALID(cmd_valid),
        .CMD_READY(cmd_ready), .CMD_STATION(cmd_station),
        .CMD_BCAST(cmd_bcast), .CMD_KIND(cmd_kind), .CMD_RESP_LEN(cmd_len),
        .CFG_BAUD(m_baud), .CFG_DELAY_MS(cfg_delay), .DONE_OK(done_ok),
        .RESP_ERR(resp_err), .RETRY(retry), .COMM_FAIL(comm_fail),
        .RETRY_COUNT(retry_count), .TIMEOUT_MS(timeout_ms));
    turn_slave #(.TICK_CYC(TK)) turn_slave_i (
        .CLK_SYS(CLK_SYS), .RST_B(RST_B), .lk(lk), .STATION_PIN(station_pin),
        .CFG_BAUD(s_baud), .CFG_DELAY_MS(cfg_delay), .CFG_XFER(cfg_xfer),
        .RESTART(restart), .PROC_REQ(proc_req), .PROC_KIND(proc_kind),
        .PROC_DONE(proc_done), .TX_DONE(tx_done), .ACTIVE_BAUD(act_baud),
        .ACTIVE_DELAY_MS(act_delay), .STATION(station), .READY(ready),
        .PROC_LATE(proc_late), .Q_DROP(q_drop));
    turn_sva #(.TICK_CYC(TK), .DLY_MS(5)) turn_sva_i (
        .CLK_SYS(CLK_SYS), .RST_B(RST_B), .q_valid(lk.q_valid),
        .q_station(lk.q_station), .q_bcast(lk.q_bcast), .q_kind(lk.q_kind),
        .q_baud(lk.q_baud), .rx_en(lk.rx_en), .tx_en(lk.tx_en),
        .r_valid(lk.r_valid), .r_station(lk.r_station), .r_err(lk.r_err));

    initial begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end

    always @(posedge CLK_SYS) cyc <= cyc + 1;

    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic int exp_tout(int k, int len);
        return 3 * lim[k] + 5 + (10 * (len + 8) * 1000 + BPS - 1) / BPS;
    endfunction

    // Pulses are one cycle wide, so they are counted at every falling edge
    always @(negedge CLK_SYS) begin
        if (retry === 1'b1) n_retry++;
        if (proc_late === 1'b1) n_late++;
        if (q_drop === 1'b1) n_drop++;
        if (lk.r_valid === 1'b1) n_resp++;
        if (done_ok === 1'b1) got_ok = 1'b1;
        if (comm_fail === 1'b1) got_fail = 1'b1;
    end

    // Processing engine stand-in; skip_done lets processing overrun
    initial forever begin
        @(negedge CLK_SYS);
        if (proc_req === 1'b1 && skip_done == 0) begin
            check(proc_kind === cmd_kind, "processing kind");
            repeat (proc_wait) @(negedge CLK_SYS);
            proc_done = 1'b1;
            done_cyc = cyc;
            @(negedge CLK_SYS);
            proc_done = 1'b0;
        end
    end

    // Serializer stand-in: finishes a few cycles after transmit starts
    initial forever begin
        @(negedge CLK_SYS);
        if (lk.tx_en === 1'b1) begin
            if (skip_done == 0) begin
                check(cyc - done_cyc > int'(cfg_delay) * TK &&
                      cyc - done_cyc <= (int'(cfg_delay) + 1) * TK + 3,
                      "turnaround delay");
            end
            repeat (3) @(negedge CLK_SYS);
            tx_done = 1'b1;
            @(negedge CLK_SYS);
            tx_done = 1'b0;
        end
    end

    task automatic transact(input station_t st, input logic bc,
                            input kind_e k, input logic [7:0] len);
        n = 0;
        while (cmd_ready !== 1'b1 && n < 4000) begin
            @(negedge CLK_SYS);
            n++;
        end
        check(n < 4000, "master ready");
        cmd_station = st;
        cmd_bcast = bc;
        cmd_kind = k;
        cmd_len = len;
        got_ok = 1'b0;
        got_fail = 1'b0;
        cmd_valid = 1'b1;
        @(negedge CLK_SYS);
        cmd_valid = 1'b0;
        @(negedge CLK_SYS);
        n = 0;
        while (!got_ok && !got_fail && (!bc || cmd_ready !== 1'b1)
               && n < 8000) begin
            @(negedge CLK_SYS);
            n++;
        end
        check(n < 8000, "unit ends");
    endtask

    // Run needs a few thousand cycles; limit leaves a wide margin
    initial begin
        repeat (30000) @(posedge CLK_SYS);
        bad_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        results();
    end

    initial begin
        {RST_B, cmd_valid, cmd_bcast, cfg_xfer, restart} = '0;
        {proc_done, tx_done, got_ok, got_fail} = '0;
        {done_cyc, n_retry, n_late, n_drop, n_resp, skip_done} = '0;
        {bad_count, n_tests, n} = '0;
        cmd_station = 4'h0;
        cmd_kind = KIND_REG;
        cmd_len = 8'h00;
        station_pin = 4'hf;
        m_baud = 4'h4;
        s_baud = 4'h4;
        cfg_delay = 8'h05;
        proc_wait = 4;
        repeat (20) @(negedge CLK_SYS);
        RST_B = 1'b1;
        @(negedge CLK_SYS);
        check(ready === 1'b1 && cmd_ready === 1'b1, "idle after reset");
        check(act_baud === 4'h4 && act_delay === 8'h05, "config reset");
        repeat (3) @(negedge CLK_SYS);
        check(station === 4'hf, "station number");
        for (int k = 0; k < 7; k++) begin
            transact(4'hf, 1'b0, kind_e'(k), 8'(4 + k));
            check(got_ok === 1'b1 && resp_err === 1'b0, "response");
            check(timeout_ms === 16'(exp_tout(k, 4 + k)),
                  "timeout");
            check(retry_count === 2'h0, "retries clear");
            n = 0;
            while (ready !== 1'b1 && n < TK + 2) begin
                @(negedge CLK_SYS);
                n++;
            end
            check(ready === 1'b1, "slave ready again");
        end
        skip_done = 1;
        transact(4'hf, 1'b0, KIND_REG, 8'h08);
        check(n_late == 1 && got_ok === 1'b1 && resp_err === 1'b1,
              "overrun");
        skip_done = 0;
        n_resp = 0;
        transact(4'h0, 1'b1, KIND_REG, 8'h08);
        check(n_resp == 0 && cmd_ready === 1'b1, "broadcast");
        transact(4'h3, 1'b0, KIND_REG, 8'h08);
        check(n_retry == 3 && got_fail === 1'b1,
              "retry limit");
        check(retry_count === 2'h0, "retry count cleared");
        s_baud = 4'h2;
        cfg_delay = 8'h07;
        cfg_xfer = 1'b1;
        @(negedge CLK_SYS);
        cfg_xfer = 1'b0;
        check(act_baud === 4'h4 && act_delay === 8'h05,
              "rate staged only");
        restart = 1'b1;
        @(negedge CLK_SYS);
        restart = 1'b0;
        @(negedge CLK_SYS);
        check(act_baud === 4'h2 && act_delay === 8'h07, "restart");
        transact(4'hf, 1'b0, KIND_REG, 8'h08);
        check(n_drop == 4 && got_fail === 1'b1, "rate mismatch");
        m_baud = 4'h2;
        transact(4'hf, 1'b0, KIND_P1_RD, 8'h08);
        check(got_ok === 1'b1, "matched rate");
        results();
    end
endmodule
